/* inc/reset_straps_defs.svh */
// offsets, field positions, reset values and timing counts
`ifndef RESET_STRAPS_DEFS_SVH
`define RESET_STRAPS_DEFS_SVH
`define BUS_SEL_ADDR 16'h1c00
`define BUS_SEL_RESET 16'h0000
`define PP_MSB 14
`define PP_LSB 12
`define SP1_MSB 11
`define SP1_LSB 10
`define SP0_MSB 9
`define SP0_LSB 8
`define ADDR_GPIO_MSB 5
`define ADDR_GPIO_LSB 0
`define ADDR_GPIO_PINS 6
`define STRAP_SETTLE 2'h3
`endif

/* inc/reset_straps_pkg.sv */
// types shared by the strap and bus routing logic
package reset_straps_pkg;
  `include "reset_straps_defs.svh"

  // one i/o port access from the cpu
  typedef struct packed {
    logic [15:0] addr;
    logic wr;
    logic rd;
    logic [15:0] wdata;
  } ioReq_s;

  // live fields of the bus select register
  typedef struct packed {
    logic [2:0] ppRoute;
    logic [1:0] sp1Route;
    logic [1:0] sp0Route;
    logic [`ADDR_GPIO_PINS-1:0] addrGpio;
  } busSel_s;
endpackage : reset_straps_pkg

/* logic/bus_select_reg.sv */
// bus select register on the cpu i/o port
`timescale 1ns/10ps
`include "reset_straps_defs.svh"
module bus_select_reg
  import reset_straps_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire ioReq_s ioReq,
  output logic [15:0] rdData,
  output logic rdValid,
  output busSel_s busSel
);
  busSel_s busSel_q;
  busSel_s busSel_d;
  logic [15:0] rdData_q;
  logic rdValid_q;
  wire logic hit;
  wire logic [15:0] rdWord;
  // reset fields cut from the full word; reserved bits are skipped
  localparam logic [15:0] RESET_WORD = `BUS_SEL_RESET;
  localparam busSel_s RESET_FIELDS =
    {RESET_WORD[`PP_MSB:`SP0_LSB],
     RESET_WORD[`ADDR_GPIO_MSB:`ADDR_GPIO_LSB]};

  // decode; reserved bits 15, 7, 6 are never stored
  assign hit = (ioReq.addr == `BUS_SEL_ADDR);
  assign busSel_d.ppRoute = ioReq.wdata[`PP_MSB:`PP_LSB];
  assign busSel_d.sp1Route = ioReq.wdata[`SP1_MSB:`SP1_LSB];
  assign busSel_d.sp0Route = ioReq.wdata[`SP0_MSB:`SP0_LSB];
  assign busSel_d.addrGpio = ioReq.wdata[`ADDR_GPIO_MSB:`ADDR_GPIO_LSB];
  assign rdWord = {1'b0, busSel_q.ppRoute, busSel_q.sp1Route,
                   busSel_q.sp0Route, 2'h0, busSel_q.addrGpio};

  // store on write; routing follows on the next cycle
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      busSel_q <= RESET_FIELDS;
    else if (ioReq.wr && hit)
      busSel_q <= busSel_d;
  end

  // read answer one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rdData_q <= 16'h0000;
      rdValid_q <= 1'b0;
    end
    else
    begin
      rdData_q <= (ioReq.rd && hit) ? rdWord : 16'h0000;
      rdValid_q <= ioReq.rd;
    end
  end

  assign rdData = rdData_q;
  assign rdValid = rdValid_q;
  assign busSel = busSel_q;

  property p_write_store;
    @(posedge sys_clk) disable iff (!rstn)
    (ioReq.wr && hit) |=> (busSel_q == $past(busSel_d));
  endproperty
  a_write_store: assert property (p_write_store)
    else $error("bus select write not stored");

  property p_other_addr;
    @(posedge sys_clk) disable iff (!rstn)
    (ioReq.wr && !hit) |=> $stable(busSel_q);
  endproperty
  a_other_addr: assert property (p_other_addr)
    else $error("write to other address changed bus select");

  property p_reserved_zero;
    @(posedge sys_clk) disable iff (!rstn)
    rdValid_q |-> (rdData_q[15] == 1'b0 && rdData_q[7:6] == 2'h0);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved bits read nonzero");

  property p_read_back;
    @(posedge sys_clk) disable iff (!rstn)
    (ioReq.rd && hit && !ioReq.wr) |=>
      (rdValid_q && rdData_q == $past(rdWord));
  endproperty
  a_read_back: assert property (p_read_back)
    else $error("bus select read mismatch");
endmodule : bus_select_reg

/* logic/reset_straps_and_bus_routing.sv */
// reset straps, clock source select and external bus routing
// What this block does
// - regulator strap low: internal reset is supply-ok AND reset pin
// - regulator strap high: supply-ok forced high, reset pin alone resets
// - clock strap low: 32 kHz oscillator feeds rtc and clock generator
// - clock strap high: external clock to generator, oscillator to rtc only
// - bits 14:12 select parallel port routing, reset 000
// - bits 11:10 and 9:8 select serial port 1 and 0 routing, reset 00
// - bus select register sits at i/o port 0x1c00, read and write
// - changed routing takes effect on the next clock cycle
// - bits 5:0 each govern one upper address pin, address 20 down to 15
// - select bit 1: that address pin works as general-purpose i/o
// - select bit 0, the reset value: pin stays a memory address line
`timescale 1ns/10ps
`include "reset_straps_defs.svh"
module reset_straps_and_bus_routing
  import reset_straps_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic resetPinN,
  input wire logic supplyOkMon,
  input wire logic coreRegulatorEnableStrap,
  input wire logic clockSourceStrap,
  input wire ioReq_s ioReq,
  output logic [15:0] ioRdData,
  output logic ioRdValid,
  output logic internalRstN,
  output logic supplyOk,
  output logic sysClkFromExt,
  output logic extClkIgnored,
  output logic [2:0] parallelPortRouting,
  output logic [1:0] serialPort1Routing,
  output logic [1:0] serialPort0Routing,
  input wire logic [`ADDR_GPIO_PINS-1:0] emifAddrHi,
  input wire logic [`ADDR_GPIO_PINS-1:0] gpioOut,
  input wire logic [`ADDR_GPIO_PINS-1:0] gpioOe,
  output logic [`ADDR_GPIO_PINS-1:0] gpioIn,
  input wire logic [`ADDR_GPIO_PINS-1:0] addrPinIn,
  output logic [`ADDR_GPIO_PINS-1:0] addrPinOut,
  output logic [`ADDR_GPIO_PINS-1:0] addrPinOe
);
  logic [3:0] pinSync1_q;
  logic [3:0] pinSync2_q;
  logic [1:0] settleCnt_q;
  logic strapsTaken_q;
  logic regStrap_q;
  logic clkStrap_q;
  logic supplyOk_q;
  logic internalRstN_q;
  logic [`ADDR_GPIO_PINS-1:0] padSync1_q;
  logic [`ADDR_GPIO_PINS-1:0] padSync2_q;
  busSel_s busSel;
  wire logic rstPinS;
  wire logic supOkS;
  wire logic supplyOk_d;
  wire logic internalRstN_d;

  // register slave on the cpu i/o port
  bus_select_reg u_bus_select_reg (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .ioReq(ioReq),
    .rdData(ioRdData),
    .rdValid(ioRdValid),
    .busSel(busSel)
  );

  // pins come from outside the clock domain: two flops first
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pinSync1_q <= 4'h0;
      pinSync2_q <= 4'h0;
    end
    else
    begin
      pinSync1_q <= {resetPinN, supplyOkMon,
                     coreRegulatorEnableStrap, clockSourceStrap};
      pinSync2_q <= pinSync1_q;
    end
  end

  assign rstPinS = pinSync2_q[3];
  assign supOkS = pinSync2_q[2];

  // straps are caught once after release, so a change needs a reset
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      settleCnt_q <= 2'h0;
      strapsTaken_q <= 1'b0;
      regStrap_q <= 1'b0;
      clkStrap_q <= 1'b0;
    end
    else if (!strapsTaken_q)
    begin
      settleCnt_q <= settleCnt_q + 2'h1;
      if (settleCnt_q == `STRAP_SETTLE)
      begin
        strapsTaken_q <= 1'b1;
        regStrap_q <= pinSync2_q[1];
        clkStrap_q <= pinSync2_q[0];
      end
    end
  end

  // supply-ok bypass and reset qualification
  assign supplyOk_d = strapsTaken_q & (regStrap_q | supOkS);
  assign internalRstN_d = supplyOk_d & rstPinS;

  // internal reset held low until the straps are known
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      supplyOk_q <= 1'b0;
      internalRstN_q <= 1'b0;
    end
    else
    begin
      supplyOk_q <= supplyOk_d;
      internalRstN_q <= internalRstN_d;
    end
  end

  assign supplyOk = supplyOk_q;
  assign internalRstN = internalRstN_q;

  // clock source steering; the rtc always stays on the oscillator
  assign sysClkFromExt = clkStrap_q;
  assign extClkIgnored = ~clkStrap_q;

  // routing fields go straight from the register, one cycle after a write
  assign parallelPortRouting = busSel.ppRoute;
  assign serialPort1Routing = busSel.sp1Route;
  assign serialPort0Routing = busSel.sp0Route;

  // per address pin: emif address line or general-purpose i/o
  genvar i;
  generate
    for (i = 0; i < `ADDR_GPIO_PINS; i++)
    begin : g_addr_pin
      wire logic gpioMode;
      assign gpioMode = busSel.addrGpio[i];
      assign addrPinOut[i] = gpioMode ? gpioOut[i]
                                      : emifAddrHi[i];
      assign addrPinOe[i] = gpioMode ? gpioOe[i] : 1'b1;
      // pad level reaches the gpio only in gpio mode
      always_ff @(posedge sys_clk or negedge rstn)
      begin
        if (!rstn)
        begin
          padSync1_q[i] <= 1'b0;
          padSync2_q[i] <= 1'b0;
        end
        else
        begin
          padSync1_q[i] <= addrPinIn[i];
          padSync2_q[i] <= padSync1_q[i];
        end
      end
      assign gpioIn[i] = gpioMode & padSync2_q[i];
    end
  endgenerate

  property p_rst_and;
    @(posedge sys_clk) disable iff (!rstn)
    (strapsTaken_q && !regStrap_q) |=>
      (internalRstN_q == $past(supOkS && rstPinS));
  endproperty
  a_rst_and: assert property (p_rst_and)
    else $error("reset not supply-ok and reset pin");

  property p_bypass;
    @(posedge sys_clk) disable iff (!rstn)
    (strapsTaken_q && regStrap_q) |=>
      (supplyOk_q && internalRstN_q == $past(rstPinS));
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("bypass did not force supply ok");

  property p_clk_osc;
    @(posedge sys_clk) disable iff (!rstn)
    (strapsTaken_q && !clkStrap_q) |-> (extClkIgnored && !sysClkFromExt);
  endproperty
  a_clk_osc: assert property (p_clk_osc)
    else $error("oscillator source not selected");

  property p_clk_ext;
    @(posedge sys_clk) disable iff (!rstn)
    $rose(strapsTaken_q) |-> (sysClkFromExt == $past(pinSync2_q[0]));
  endproperty
  a_clk_ext: assert property (p_clk_ext)
    else $error("clock strap not taken");

  property p_strap_hold;
    @(posedge sys_clk) disable iff (!rstn)
    strapsTaken_q |=> ($stable(clkStrap_q) && $stable(regStrap_q));
  endproperty
  a_strap_hold: assert property (p_strap_hold)
    else $error("strap changed without reset");

  property p_route_next;
    @(posedge sys_clk) disable iff (!rstn)
    (ioReq.wr && ioReq.addr == `BUS_SEL_ADDR) |=>
      (parallelPortRouting == $past(ioReq.wdata[`PP_MSB:`PP_LSB]) &&
       serialPort1Routing == $past(ioReq.wdata[`SP1_MSB:`SP1_LSB]) &&
       serialPort0Routing == $past(ioReq.wdata[`SP0_MSB:`SP0_LSB]));
  endproperty
  a_route_next: assert property (p_route_next)
    else $error("routing not applied next cycle");

  property p_gpio_pin;
    @(posedge sys_clk) disable iff (!rstn)
    (ioReq.wr && ioReq.addr == `BUS_SEL_ADDR && ioReq.wdata[0]) |=>
      (addrPinOut[0] == gpioOut[0] && addrPinOe[0] == gpioOe[0]);
  endproperty
  a_gpio_pin: assert property (p_gpio_pin)
    else $error("address pin 15 not in gpio mode");

  property p_emif_pin;
    @(posedge sys_clk) disable iff (!rstn)
    (ioReq.wr && ioReq.addr == `BUS_SEL_ADDR && !ioReq.wdata[5]) |=>
      (addrPinOut[5] == emifAddrHi[5] && addrPinOe[5] && !gpioIn[5]);
  endproperty
  a_emif_pin: assert property (p_emif_pin)
    else $error("address pin 20 not an emif line");

  c_bypass: cover property (@(posedge sys_clk) disable iff (!rstn)
    strapsTaken_q && regStrap_q && internalRstN_q);
  c_ext_clk: cover property (@(posedge sys_clk) disable iff (!rstn)
    strapsTaken_q && sysClkFromExt);
  c_gpio_all: cover property (@(posedge sys_clk) disable iff (!rstn)
    busSel.addrGpio == 6'h3f && parallelPortRouting != 3'h0);
endmodule : reset_straps_and_bus_routing

/* test/tb_top.sv */
// self-checking bench for strap capture and bus select routing
`timescale 1ns/10ps
module tb_top;
  import reset_straps_pkg::*;
  logic sys_clk, rstn, resetPinN, supplyOkMon, regStrap, clkStrap;
  ioReq_s ioReq;
  logic [15:0] ioRdData;
  logic ioRdValid, internalRstN, supplyOk, sysClkFromExt, extClkIgnored;
  logic [2:0] ppRoute;
  logic [1:0] sp1Route, sp0Route;
  logic [5:0] emifAddrHi, gpioOut, gpioOe, gpioIn, addrPinIn;
  logic [5:0] addrPinOut, addrPinOe;
  wire logic [15:0] fieldWord = {9'h0, ppRoute, sp1Route, sp0Route};
  wire logic [1:0] clkSel = {sysClkFromExt, extClkIgnored};
  int failures, checks, cycles;

  reset_straps_and_bus_routing i_reset_straps_and_bus_routing (
    .sys_clk(sys_clk), .rstn(rstn), .resetPinN(resetPinN),
    .supplyOkMon(supplyOkMon), .coreRegulatorEnableStrap(regStrap),
    .clockSourceStrap(clkStrap), .ioReq(ioReq), .ioRdData(ioRdData),
    .ioRdValid(ioRdValid), .internalRstN(internalRstN),
    .supplyOk(supplyOk), .sysClkFromExt(sysClkFromExt),
    .extClkIgnored(extClkIgnored), .parallelPortRouting(ppRoute),
    .serialPort1Routing(sp1Route), .serialPort0Routing(sp0Route),
    .emifAddrHi(emifAddrHi), .gpioOut(gpioOut), .gpioOe(gpioOe),
    .gpioIn(gpioIn), .addrPinIn(addrPinIn), .addrPinOut(addrPinOut),
    .addrPinOe(addrPinOe));

  // 100 ns clock
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // hang guard; the whole run needs about 120 cycles
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles >= 5000)
    begin
      failures++;
      results();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : tick

  task automatic check(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // write strobe held for exactly one rising edge; the register stores on that edge
  task automatic regWrite(input logic [15:0] addr, input logic [15:0] data);
    ioReq.addr = addr;
    ioReq.wdata = data;
    ioReq.wr = 1'b1;
    tick(1);
    ioReq.wr = 1'b0;
  endtask : regWrite

  // answer stands one cycle, so it is judged right after the taking edge
  task automatic regRead(input logic [15:0] addr, input logic [15:0] exp);
    ioReq.addr = addr;
    ioReq.rd = 1'b1;
    tick(1);
    ioReq.rd = 1'b0;
    check("rdValid", 16'(ioRdValid), 16'h0001);
    check("rdData", ioRdData, exp);
  endtask : regRead

  // straps only move while rstn is low, so every change is reset in
  task automatic applyReset(input logic r, input logic c);
    rstn = 1'b0;
    regStrap = r;
    clkStrap = c;
    tick(20);
    rstn = 1'b1;
    tick(8);
  endtask : applyReset

  task automatic checkPins(input logic [5:0] sel);
    logic [5:0] expOut;
    logic [5:0] expOe;
    expOut = (gpioOut & sel) | (emifAddrHi & ~sel);
    expOe = (gpioOe & sel) | ~sel;
    check("pinOut", 16'(addrPinOut), 16'(expOut));
    check("pinOe", 16'(addrPinOe), 16'(expOe));
  endtask : checkPins

  task automatic testDefaults();
    check("fields", fieldWord, 16'h0000);
    checkPins(6'h00);
    regRead(16'h1c00, 16'h0000);
  endtask : testDefaults

  // routing programmed by software after reset
  task automatic testFields();
    regWrite(16'h1c00, 16'hffff);
    check("fields", fieldWord, 16'h007f);
    regRead(16'h1c00, 16'h7f3f);
    regWrite(16'h1c00, 16'h5003);
    check("ppRoute", 16'(ppRoute), 16'h0005);
    check("spRoute", 16'({sp1Route, sp0Route}), 16'h0000);
    // idle edge so a strobe is never driven twice in one step
    tick(1);
    regWrite(16'h1c01, 16'h0000);
    regRead(16'h1c00, 16'h5003);
    tick(1);
    regRead(16'h1c01, 16'h0000);
  endtask : testFields

  task automatic testPins();
    regWrite(16'h1c00, 16'h0803);
    check("sp1Route", 16'(sp1Route), 16'h0002);
    checkPins(6'h03);
    tick(3);
    check("gpioIn", 16'(gpioIn), 16'(addrPinIn & 6'h03));
    regWrite(16'h1c00, 16'h0120);
    check("sp0Route", 16'(sp0Route), 16'h0001);
    checkPins(6'h20);
    tick(3);
    check("gpioIn", 16'(gpioIn), 16'(addrPinIn & 6'h20));
  endtask : testPins

  task automatic testStraps();
    applyReset(1'b1, 1'b1);
    check("supplyOk", 16'(supplyOk), 16'h0001);
    check("clkSel", 16'(clkSel), 16'h0002);
    // external core supply: the board pulses the reset pin itself
    supplyOkMon = 1'b0;
    resetPinN = 1'b0;
    tick(4);
    check("intRst", 16'(internalRstN), 16'h0000);
    check("supplyOk", 16'(supplyOk), 16'h0001);
    resetPinN = 1'b1;
    tick(4);
    check("intRst", 16'(internalRstN), 16'h0001);
    // clock strap left alone while running
    check("clkHeld", 16'(sysClkFromExt), 16'h0001);
    applyReset(1'b0, 1'b0);
    check("supplyOk", 16'(supplyOk), 16'h0000);
    check("intRst", 16'(internalRstN), 16'h0000);
    check("clkSel", 16'(clkSel), 16'h0001);
    supplyOkMon = 1'b1;
    tick(4);
    check("intRst", 16'(internalRstN), 16'h0001);
    resetPinN = 1'b0;
    tick(4);
    check("intRst", 16'(internalRstN), 16'h0000);
    resetPinN = 1'b1;
    tick(4);
  endtask : testStraps

  task automatic results();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : results

  // pads given distinct patterns so a swapped source shows up
  initial
  begin
    failures = 0;
    checks = 0;
    cycles = 0;
    resetPinN = 1'b1;
    supplyOkMon = 1'b1;
    ioReq = '0;
    emifAddrHi = 6'h2a;
    gpioOut = 6'h15;
    gpioOe = 6'h3c;
    addrPinIn = 6'h0f;
    rstn = 1'b0;
    regStrap = 1'b0;
    clkStrap = 1'b0;
    applyReset(1'b0, 1'b0);
    testDefaults();
    testFields();
    testPins();
    testStraps();
    testDefaults();
    results();
  end
endmodule : tb_top
